/* common/uart_fifo_status_map.svh */
// Register offsets, field positions, reset values and bus codes of the FIFO status registers.
`ifndef UART_FIFO_STATUS_MAP_SVH
`define UART_FIFO_STATUS_MAP_SVH
`define SCRATCH_BYTE_STORE_OFS 8'h1c
`define FIFO_FLAG_STATE_OFS 8'h7c
`define TRANSMIT_QUEUE_COUNT_OFS 8'h80
`define RECEIVE_QUEUE_COUNT_OFS 8'h84
`define TRANSMIT_PAUSE_CTRL_OFS 8'ha4
`define SCRATCH_BYTE_RST 8'h00
`define FIFO_FLAG_STATE_RST 32'h00000006
`define TRANSMIT_PAUSE_RST 1'b0
`define RX_FULL_BIT 4
`define RX_NONEMPTY_BIT 3
`define TX_EMPTY_BIT 2
`define TX_NOT_FULL_BIT 1
`define PAUSE_BIT 0
`define QUEUE_LEVEL_W 5
`define QUEUE_DEPTH 16
`define SCRATCH_W 8
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

/* common/uart_fifo_status_pkg.sv */
// Types shared by the FIFO status register block.
package uart_fifo_status_pkg;
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_ADDR = 2'h1,
		WR_RESP = 2'h3,
		WR_DATA = 2'h2
	} wr_state_t;
	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_SCRATCH = 3'h1,
		SEL_FLAGS = 3'h2,
		SEL_TX_COUNT = 3'h3,
		SEL_RX_COUNT = 3'h4,
		SEL_PAUSE = 3'h5
	} reg_sel_t;
endpackage

/* core/queue_level_counter.sv */
// Occupancy counter with full and empty flags for one FIFO.
`timescale 1ns/1ps
module queue_level_counter #(
	parameter int DEPTH = 16,
	parameter int CW = 5
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic push,
	input wire logic pop,
	output logic [CW-1:0] level,
	output logic full,
	output logic empty
);
	// A push into a full queue or a pop from an empty one is dropped, so the count never wraps.
	wire push_ok = push && !full;
	wire pop_ok = pop && !empty;
	logic [CW-1:0] level_next;

	always_comb begin
		level_next = level;
		if (push_ok && !pop_ok) begin
			level_next = level + CW'(1);
		end else if (pop_ok && !push_ok) begin
			level_next = level - CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level <= '0;
			full <= 1'b0;
			empty <= 1'b1;
		end else begin
			level <= level_next;
			full <= (level_next == CW'(DEPTH));
			empty <= (level_next == '0);
		end
	end
endmodule

/* core/uart_fifo_status_regs.sv */
// Scratch byte, FIFO flags, FIFO levels and transmit pause behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "uart_fifo_status_map.svh"

// How it works
// - An 8-bit scratch byte is read and written freely and steers nothing.
// - Flag bit 4 is 1 while the receive FIFO is completely full.
// - Flag bit 3 is 1 while the receive FIFO holds at least one entry.
// - Flag bit 2 is 1 only while the transmit FIFO is empty.
// - Flag bit 1 is 1 while the transmit FIFO has free space.
// - A 5-bit read-only count gives the transmit FIFO occupancy.
// - A 5-bit read-only count gives the receive FIFO occupancy.
// - Pause bit 0 at 1 holds back the start of transmissions.
// - With FIFOs disabled the pause bit has no effect on transmission.
module uart_fifo_status_regs #(
	parameter int ADDR_W = 8,
	parameter int QUEUE_DEPTH = `QUEUE_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fifo_enable,
	input wire logic tx_push,
	input wire logic tx_pop,
	input wire logic rx_push,
	input wire logic rx_pop,
	output logic tx_start_allow,
	output logic transmit_queue_not_full,
	output logic receive_queue_nonempty,
	output logic [`QUEUE_LEVEL_W-1:0] transmit_queue_count,
	output logic [`QUEUE_LEVEL_W-1:0] receive_queue_count
);
	localparam int LW = `QUEUE_LEVEL_W;

	// Address decode is shared by the read and the write path.
	function automatic uart_fifo_status_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
		logic [7:0] ofs;
		ofs = 8'(addr);
		if (addr[ADDR_W-1:0] != ADDR_W'(ofs)) begin
			decode = uart_fifo_status_pkg::SEL_NONE;
		end else begin
			case (ofs)
				`SCRATCH_BYTE_STORE_OFS: decode = uart_fifo_status_pkg::SEL_SCRATCH;
				`FIFO_FLAG_STATE_OFS: decode = uart_fifo_status_pkg::SEL_FLAGS;
				`TRANSMIT_QUEUE_COUNT_OFS: decode = uart_fifo_status_pkg::SEL_TX_COUNT;
				`RECEIVE_QUEUE_COUNT_OFS: decode = uart_fifo_status_pkg::SEL_RX_COUNT;
				`TRANSMIT_PAUSE_CTRL_OFS: decode = uart_fifo_status_pkg::SEL_PAUSE;
				default: decode = uart_fifo_status_pkg::SEL_NONE;
			endcase
		end
	endfunction

	// Software-visible state and registered side outputs.
	logic [`SCRATCH_W-1:0] scratch_reg;
	logic pause_reg;
	logic tx_start_allow_reg;
	logic tx_nf_reg;
	logic rx_ne_reg;

	// Queue occupancy.
	logic [LW-1:0] tx_level;
	logic [LW-1:0] rx_level;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;

	queue_level_counter #(
		.DEPTH(QUEUE_DEPTH),
		.CW(LW)
	) tx_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.push(tx_push),
		.pop(tx_pop),
		.level(tx_level),
		.full(tx_full),
		.empty(tx_empty)
	);

	queue_level_counter #(
		.DEPTH(QUEUE_DEPTH),
		.CW(LW)
	) rx_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.push(rx_push),
		.pop(rx_pop),
		.level(rx_level),
		.full(rx_full),
		.empty(rx_empty)
	);

	// Flag word; bit 0 and bits above 4 are reserved and stay zero.
	wire [31:0] flag_word = {27'h0,
		rx_full,
		!rx_empty,
		tx_empty,
		!tx_full,
		1'b0};
	wire [31:0] tx_count_word = {{(32-LW){1'b0}}, tx_level};
	wire [31:0] rx_count_word = {{(32-LW){1'b0}}, rx_level};
	wire [31:0] scratch_word = {{(32-`SCRATCH_W){1'b0}}, scratch_reg};
	wire [31:0] pause_word = {31'h0, pause_reg};

	// Pause only counts when the FIFOs are in use; without them the bit is inert.
	wire start_allow_next = !(fifo_enable && pause_reg);

	// Write channel state.
	uart_fifo_status_pkg::wr_state_t wr_state_reg;
	uart_fifo_status_pkg::wr_state_t wr_state_next;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;

	wire aw_fire = s_axi_awvalid && awready_reg;
	wire w_fire = s_axi_wvalid && wready_reg;
	wire b_fire = bvalid_reg && s_axi_bready;

	always_comb begin
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			uart_fifo_status_pkg::WR_IDLE: begin
				if (aw_fire && w_fire) begin
					wr_state_next = uart_fifo_status_pkg::WR_RESP;
				end else if (aw_fire) begin
					wr_state_next = uart_fifo_status_pkg::WR_ADDR;
				end else if (w_fire) begin
					wr_state_next = uart_fifo_status_pkg::WR_DATA;
				end
			end
			uart_fifo_status_pkg::WR_ADDR: begin
				if (w_fire) begin
					wr_state_next = uart_fifo_status_pkg::WR_RESP;
				end
			end
			uart_fifo_status_pkg::WR_DATA: begin
				if (aw_fire) begin
					wr_state_next = uart_fifo_status_pkg::WR_RESP;
				end
			end
			uart_fifo_status_pkg::WR_RESP: begin
				if (b_fire) begin
					wr_state_next = uart_fifo_status_pkg::WR_IDLE;
				end
			end
			default: wr_state_next = uart_fifo_status_pkg::WR_IDLE;
		endcase
	end

	// Address and data are taken straight from the bus in the cycle they arrive, else from the latch.
	wire [ADDR_W-1:0] wr_addr = aw_fire ? s_axi_awaddr : aw_addr_reg;
	wire [31:0] wr_data = w_fire ? s_axi_wdata : w_data_reg;
	wire [3:0] wr_strb = w_fire ? s_axi_wstrb : w_strb_reg;
	wire wr_commit = (wr_state_next == uart_fifo_status_pkg::WR_RESP) &&
		(wr_state_reg != uart_fifo_status_pkg::WR_RESP);
	wire uart_fifo_status_pkg::reg_sel_t wr_sel = decode(wr_addr);
	wire wr_scratch = wr_commit && wr_strb[0] && (wr_sel == uart_fifo_status_pkg::SEL_SCRATCH);
	wire wr_pause = wr_commit && wr_strb[0] && (wr_sel == uart_fifo_status_pkg::SEL_PAUSE);
	wire [1:0] wr_resp = (wr_sel == uart_fifo_status_pkg::SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
	wire awready_next = (wr_state_next == uart_fifo_status_pkg::WR_IDLE) ||
		(wr_state_next == uart_fifo_status_pkg::WR_DATA);
	wire wready_next = (wr_state_next == uart_fifo_status_pkg::WR_IDLE) ||
		(wr_state_next == uart_fifo_status_pkg::WR_ADDR);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= uart_fifo_status_pkg::WR_IDLE;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end else begin
			wr_state_reg <= wr_state_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			if (aw_fire) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else if (wr_commit) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_resp;
		end else if (b_fire) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Only the writable registers have storage; other mapped offsets accept and drop the data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scratch_reg <= `SCRATCH_BYTE_RST;
			pause_reg <= `TRANSMIT_PAUSE_RST;
		end else begin
			if (wr_scratch) begin
				scratch_reg <= wr_data[`SCRATCH_W-1:0];
			end
			if (wr_pause) begin
				pause_reg <= wr_data[`PAUSE_BIT];
			end
		end
	end

	// Read channel: one read in flight, data registered at the address handshake.
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	wire ar_fire = s_axi_arvalid && arready_reg;
	wire r_fire = rvalid_reg && s_axi_rready;
	wire uart_fifo_status_pkg::reg_sel_t rd_sel = decode(s_axi_araddr);
	logic [31:0] rd_word;

	always_comb begin
		case (rd_sel)
			uart_fifo_status_pkg::SEL_SCRATCH: rd_word = scratch_word;
			uart_fifo_status_pkg::SEL_FLAGS: rd_word = flag_word;
			uart_fifo_status_pkg::SEL_TX_COUNT: rd_word = tx_count_word;
			uart_fifo_status_pkg::SEL_RX_COUNT: rd_word = rx_count_word;
			uart_fifo_status_pkg::SEL_PAUSE: rd_word = pause_word;
			default: rd_word = 32'h0;
		endcase
	end

	wire [1:0] rd_resp = (rd_sel == uart_fifo_status_pkg::SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= `RESP_OKAY;
		end else if (ar_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_resp;
		end else if (r_fire) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	// Side outputs other than the counts are registered copies, one cycle behind the counters and start_allow_next.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_start_allow_reg <= 1'b1;
			tx_nf_reg <= 1'b1;
			rx_ne_reg <= 1'b0;
		end else begin
			tx_start_allow_reg <= start_allow_next;
			tx_nf_reg <= !tx_full;
			rx_ne_reg <= !rx_empty;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign tx_start_allow = tx_start_allow_reg;
	assign transmit_queue_not_full = tx_nf_reg;
	assign receive_queue_nonempty = rx_ne_reg;
	assign transmit_queue_count = tx_level;
	assign receive_queue_count = rx_level;
endmodule

/* verif/uart_fifo_status_regs_sva.sv */
// Port-level checker for the FIFO status register block.
`timescale 1ns/1ps
`include "uart_fifo_status_map.svh"
module status_regs_checker #(
	parameter int QUEUE_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic fifo_enable,
	input wire logic tx_push,
	input wire logic tx_pop,
	input wire logic rx_push,
	input wire logic rx_pop,
	input wire logic tx_start_allow,
	input wire logic transmit_queue_not_full,
	input wire logic receive_queue_nonempty,
	input wire logic [`QUEUE_LEVEL_W-1:0] transmit_queue_count,
	input wire logic [`QUEUE_LEVEL_W-1:0] receive_queue_count
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_taken |=> s_axi_bvalid)
		else $error("write answer missing");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	a_tx_not_full: assert property (transmit_queue_not_full == ($past(transmit_queue_count) != QUEUE_DEPTH))
		else $error("not full output wrong");
	a_rx_nonempty: assert property (receive_queue_nonempty == ($past(receive_queue_count) != 0))
		else $error("nonempty output wrong");
	a_tx_count_up: assert property (tx_push && !tx_pop && transmit_queue_count < QUEUE_DEPTH
		|=> transmit_queue_count == $past(transmit_queue_count) + 1'b1)
		else $error("transmit count did not rise");
	a_rx_count_down: assert property (rx_pop && !rx_push && receive_queue_count != 0
		|=> receive_queue_count == $past(receive_queue_count) - 1'b1)
		else $error("receive count did not fall");
	a_pause_ignored: assert property (!fifo_enable |=> tx_start_allow)
		else $error("start held with queues off");
	a_count_bound: assert property (transmit_queue_count <= QUEUE_DEPTH && receive_queue_count <= QUEUE_DEPTH)
		else $error("count above depth");
endmodule
bind uart_fifo_status_regs status_regs_checker #(.QUEUE_DEPTH(QUEUE_DEPTH)) i_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .fifo_enable, .tx_push, .tx_pop, .rx_push, .rx_pop, .tx_start_allow,
	.transmit_queue_not_full, .receive_queue_nonempty, .transmit_queue_count, .receive_queue_count);

/* verif/uart_far_side.sv */
// Behavioural far side: a transmitter draining the queue and a receiver filling it.
`timescale 1ns/1ps
`include "uart_fifo_status_map.svh"
module uart_far_side (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic drain_en,
	input wire logic rx_send,
	input wire logic tx_start_allow,
	input wire logic [`QUEUE_LEVEL_W-1:0] transmit_queue_count,
	output logic tx_pop,
	output logic rx_push
);
	// Pulses are spaced one idle cycle apart so the count has settled before the next decision.
	always_ff @(posedge aclk) begin
		tx_pop <= aresetn && drain_en && tx_start_allow && !tx_pop && transmit_queue_count != 0;
		rx_push <= aresetn && rx_send && !rx_push;
	end
endmodule

/* verif/tb_uart_fifo_status_regs.sv */
// Self-checking bench for the FIFO status register block.
`timescale 1ns/1ps
`include "uart_fifo_status_map.svh"
module tb_uart_fifo_status_regs;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ta;
	logic fifo_enable = 1'b0, tx_push = 1'b0, rx_pop = 1'b0, drain_en = 1'b0, rx_send = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] wdata = 32'h0, rd, rdata;
	logic [1:0] rs, bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, tx_pop, rx_push, tx_start_allow, tx_nf, rx_ne;
	logic [4:0] tx_cnt, rx_cnt;
	int num_errors = 0, n_checks = 0, n;
	logic [7:0] ofs [5] = '{`SCRATCH_BYTE_STORE_OFS, `FIFO_FLAG_STATE_OFS, `TRANSMIT_QUEUE_COUNT_OFS,
		`RECEIVE_QUEUE_COUNT_OFS, `TRANSMIT_PAUSE_CTRL_OFS};
	logic [31:0] rst [5] = '{32'h0, `FIFO_FLAG_STATE_RST, 32'h0, 32'h0, 32'h0};
	always #50 aclk = ~aclk;
	uart_fifo_status_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .fifo_enable(fifo_enable), .tx_push(tx_push), .tx_pop(tx_pop),
		.rx_push(rx_push), .rx_pop(rx_pop), .tx_start_allow(tx_start_allow), .transmit_queue_not_full(tx_nf),
		.receive_queue_nonempty(rx_ne), .transmit_queue_count(tx_cnt), .receive_queue_count(rx_cnt));
	uart_far_side i_far (.aclk(aclk), .aresetn(aresetn), .drain_en(drain_en), .rx_send(rx_send),
		.tx_start_allow(tx_start_allow), .transmit_queue_count(tx_cnt), .tx_pop(tx_pop), .rx_push(rx_push));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task guard;
		n++;
		if (n > 300) begin
			num_errors++;
			final_report;
		end
	endtask
	// Ready is judged at the falling edge so the handshake edge itself never races the bench.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic tw;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			guard;
		end while ((awvalid && !ta) || (wvalid && !tw));
		do begin
			@(negedge aclk);
			ta = bvalid;
			rs = bresp;
			@(posedge aclk);
			guard;
		end while (!ta);
		chk(rs, er);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			ta = arready;
			@(posedge aclk);
			guard;
		end while (!ta);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			ta = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			guard;
		end while (!ta);
		chk(rd, e);
		chk(rs, er);
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 5; i++)
			rdchk(ofs[i], rst[i], `RESP_OKAY);
		wr(`SCRATCH_BYTE_STORE_OFS, 32'hffffffa5, `RESP_OKAY);
		rdchk(`SCRATCH_BYTE_STORE_OFS, 32'ha5, `RESP_OKAY);
		// A write without the low byte lane enabled must leave the scratch byte alone.
		wstrb <= 4'he;
		wr(`SCRATCH_BYTE_STORE_OFS, 32'h5a, `RESP_OKAY);
		wstrb <= 4'hf;
		rdchk(`SCRATCH_BYTE_STORE_OFS, 32'ha5, `RESP_OKAY);
		wr(`FIFO_FLAG_STATE_OFS, 32'hffffffff, `RESP_OKAY);
		rdchk(`FIFO_FLAG_STATE_OFS, 32'h6, `RESP_OKAY);
		wr(8'h40, 32'h1, `RESP_DECERR);
		rdchk(8'h40, 32'h0, `RESP_DECERR);
		fifo_enable <= 1'b1;
		drain_en <= 1'b1;
		wr(`TRANSMIT_PAUSE_CTRL_OFS, 32'hffffffff, `RESP_OKAY);
		rdchk(`TRANSMIT_PAUSE_CTRL_OFS, 32'h1, `RESP_OKAY);
		chk(tx_start_allow, 1'b0);
		repeat (17) begin
			tx_push <= 1'b1;
			@(posedge aclk);
			tx_push <= 1'b0;
			@(posedge aclk);
		end
		wr(`TRANSMIT_QUEUE_COUNT_OFS, 32'h0, `RESP_OKAY);
		rdchk(`TRANSMIT_QUEUE_COUNT_OFS, 32'h10, `RESP_OKAY);
		rdchk(`FIFO_FLAG_STATE_OFS, 32'h0, `RESP_OKAY);
		chk(tx_nf, 1'b0);
		fifo_enable <= 1'b0;
		n = 0;
		while (tx_cnt !== 5'h00) begin
			@(posedge aclk);
			guard;
		end
		chk(tx_start_allow, 1'b1);
		rdchk(`FIFO_FLAG_STATE_OFS, 32'h6, `RESP_OKAY);
		rx_send <= 1'b1;
		repeat (40) @(posedge aclk);
		rx_send <= 1'b0;
		rdchk(`RECEIVE_QUEUE_COUNT_OFS, 32'h10, `RESP_OKAY);
		rdchk(`FIFO_FLAG_STATE_OFS, 32'h1e, `RESP_OKAY);
		rx_pop <= 1'b1;
		@(posedge aclk);
		rx_pop <= 1'b0;
		rdchk(`FIFO_FLAG_STATE_OFS, 32'he, `RESP_OKAY);
		wr(`RECEIVE_QUEUE_COUNT_OFS, 32'h0, `RESP_OKAY);
		rdchk(`RECEIVE_QUEUE_COUNT_OFS, 32'hf, `RESP_OKAY);
		chk(rx_ne, 1'b1);
		chk(rx_cnt, 32'hf);
		// A reset in mid-run must bring every register and both counts back to their reset values.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 5; i++)
			rdchk(ofs[i], rst[i], `RESP_OKAY);
		chk(rx_ne, 1'b0);
		chk(tx_start_allow, 1'b1);
		final_report;
	end
endmodule
